// [hw/pmucr_params.svh]
// constants for the clock, dimming and regulator register bank
// What this block does
// - dimming field bits 4:3 selects four frequencies
// - clock output held low when disabled
// - enable forces oscillator on, output toggles
// - output toggles only while regulator one on
// - divider bits 1:0 give 1,2,4,8 division
// - five-bit read-only led current, default 01000
// - power good sets at 95%, clears 90%
// - power good flags bits 5,4 are live
// - regulator enables bits 1,0, reset zero
// - defaults loaded from otp at lockout release
// - lockout or bus stop resets serial interface
`ifndef PMUCR_PARAMS_SVH
`define PMUCR_PARAMS_SVH

`define PMUCR_ADDR_CTL 8'h03
`define PMUCR_ADDR_LED 8'h04
`define PMUCR_ADDR_REG 8'h05

`define PMUCR_DIM_LSB 3
`define PMUCR_DIM_MSB 4
`define PMUCR_CLKEN_BIT 2
`define PMUCR_DIV_LSB 0
`define PMUCR_DIV_MSB 1
`define PMUCR_LED_LSB 0
`define PMUCR_LED_MSB 4
`define PMUCR_PG2_BIT 5
`define PMUCR_PG1_BIT 4
`define PMUCR_EN2_BIT 1
`define PMUCR_EN1_BIT 0

`define PMUCR_DIM_RST 2'h3
`define PMUCR_CLKEN_RST 1'h0
`define PMUCR_DIV_RST 2'h0
`define PMUCR_DIV_BYPASS 2'h0
`define PMUCR_LED_RST 5'h08
`define PMUCR_EN_RST 2'h0

`define PMUCR_CLK_HZ 250000000
`define PMUCR_DIM_BASE_HZ 23500
`define PMUCR_DIM_BASE_CYC (`PMUCR_CLK_HZ / `PMUCR_DIM_BASE_HZ)
`define PMUCR_DIM_CNT_W 17

`endif

// [hw/pmucr_pkg.sv]
// types used by the register bank for address decode and read data
package pmucr_pkg;
  typedef logic [7:0] pmucr_byte_t;
  typedef enum {
    PMUCR_SEL_CTL,
    PMUCR_SEL_LED,
    PMUCR_SEL_REG,
    PMUCR_SEL_NONE
  } pmucr_regsel_t;
endpackage

// [hw/pmucr_gen_if.sv]
// control and output wires between bank and generators
`timescale 1ns/10ps
interface pmucr_gen_if;
  logic clk_en;
  logic reg_one_on;
  logic [1:0] div_sel;
  logic [1:0] dim_sel;
  logic clk_pin;
  logic dim_pwm;
  modport bank (
    output clk_en,
    output reg_one_on,
    output div_sel,
    output dim_sel,
    input clk_pin,
    input dim_pwm
  );
  modport clkgen (
    input clk_en,
    input reg_one_on,
    input div_sel,
    output clk_pin
  );
  modport dimgen (
    input dim_sel,
    output dim_pwm
  );
endinterface

// [hw/pmucr_clock_output_pin.sv]
// divided oscillator clock output
`timescale 1ns/10ps
`include "pmucr_params.svh"
module pmucr_clock_output_pin (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic osc_pin,
  pmucr_gen_if.clkgen gen
);
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_prev_q;
  logic [1:0] edge_cnt_q;
  logic out_q;
  logic run;
  logic rise;

  // oscillator rising edges per half period, minus one
  function automatic logic [1:0] last_edge(input logic [1:0] sel);
    case (sel)
      2'h2: last_edge = 2'h1;
      2'h3: last_edge = 2'h3;
      default: last_edge = 2'h0;
    endcase
  endfunction

  assign run = gen.clk_en & gen.reg_one_on;
  assign rise = osc_s2_q & ~osc_prev_q;
  assign gen.clk_pin = out_q;

  always_ff @(posedge clk_sys)
  begin
    osc_s1_q <= osc_pin;
    osc_s2_q <= osc_s1_q;
    osc_prev_q <= osc_s2_q;
  end

  // out_q is the pin; it parks low so the pin never glitches
  always_ff @(posedge clk_sys)
  begin
    if (rst || !run)
    begin
      edge_cnt_q <= 2'h0;
      out_q <= 1'b0;
    end
    else if (gen.div_sel == `PMUCR_DIV_BYPASS)
    begin
      edge_cnt_q <= 2'h0;
      out_q <= osc_s2_q;
    end
    else if (rise)
    begin
      if (edge_cnt_q == last_edge(gen.div_sel))
      begin
        edge_cnt_q <= 2'h0;
        out_q <= ~out_q;
      end
      else
      begin
        edge_cnt_q <= edge_cnt_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  stop_low_a: assert property (!run |=> !out_q)
    else $error("clock output not low while disabled");
  toggle_gate_a: assert property ($rose(out_q) |-> $past(run))
    else $error("clock output rose without regulator one");
  div_eight_a: assert property (
    $changed(out_q) && gen.div_sel == 2'h3 |=>
    ($stable(out_q) || !run || gen.div_sel != 2'h3) [*8])
    else $error("divide by eight output toggled too fast");
  div_eight_c: cover property ($changed(out_q) && gen.div_sel == 2'h3);
endmodule

// [hw/pmucr_dimgen.sv]
// dimming pwm frequency generator
`timescale 1ns/10ps
`include "pmucr_params.svh"
module pmucr_dimgen #(
  parameter int BASE_CYCLES = `PMUCR_DIM_BASE_CYC,
  parameter int CNT_W = `PMUCR_DIM_CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  pmucr_gen_if.dimgen gen
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] half;
  logic pwm_q;

  // each step of the field halves the frequency
  assign half = CNT_W'(BASE_CYCLES / 2) << gen.dim_sel;
  assign gen.dim_pwm = pwm_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      pwm_q <= 1'b0;
    end
    else if (cnt_q >= half - CNT_W'(1))
    begin
      cnt_q <= '0;
      pwm_q <= ~pwm_q;
    end
    else
    begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  dim_hold_a: assert property (
    $changed(pwm_q) && $stable(gen.dim_sel) |=>
    ($stable(pwm_q) || $changed(gen.dim_sel)) [*8])
    else $error("dimming output toggled too early");
  dim_toggle_c: cover property ($changed(pwm_q) && gen.dim_sel == 2'h0);
endmodule

// [hw/pmucr_top.sv]
// clock, dimming and regulator control register bank
`timescale 1ns/10ps
`include "pmucr_params.svh"
module pmucr_top #(
  parameter int DIM_BASE_CYCLES = `PMUCR_DIM_BASE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic undervoltage_lockout_pin,
  input wire logic bus_stop,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic [7:0] otp_ctl,
  input wire logic [4:0] otp_led,
  input wire logic [1:0] otp_reg_en,
  input wire logic osc_pin,
  input wire logic reg_one_above_pin,
  input wire logic reg_one_below_pin,
  input wire logic reg_two_above_pin,
  input wire logic reg_two_below_pin,
  output logic clock_output_pin_q,
  output logic dim_pwm_q,
  output logic osc_force_on_q,
  output logic reg_one_enable_q,
  output logic reg_two_enable_q,
  output logic reg_one_power_good_q,
  output logic reg_two_power_good_q,
  output logic serial_if_reset_q
);
  pmucr_gen_if gen ();

  // async levels: lockout, above 95% pair, below 90% pair
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic undervoltage_lockout_s;
  logic undervoltage_lockout_prev_q;
  logic load;
  logic wr_ok;
  logic [1:0] above_s;
  logic [1:0] below_s;

  logic [1:0] dim_sel_q;
  logic clk_en_q;
  logic [1:0] div_sel_q;
  logic [4:0] led_level_q;
  logic [1:0] reg_en_q;
  logic [1:0] reg_en_d;
  logic [1:0] pgood_q;
  pmucr_pkg::pmucr_byte_t rdata_d;

  function automatic pmucr_pkg::pmucr_regsel_t decode(input logic [7:0] a);
    if (a == `PMUCR_ADDR_CTL)
      decode = pmucr_pkg::PMUCR_SEL_CTL;
    else if (a == `PMUCR_ADDR_LED)
      decode = pmucr_pkg::PMUCR_SEL_LED;
    else if (a == `PMUCR_ADDR_REG)
      decode = pmucr_pkg::PMUCR_SEL_REG;
    else
      decode = pmucr_pkg::PMUCR_SEL_NONE;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    sync1_q <= {reg_two_below_pin, reg_two_above_pin,
                reg_one_below_pin, reg_one_above_pin, undervoltage_lockout_pin};
    sync2_q <= sync1_q;
  end

  assign undervoltage_lockout_s = sync2_q[0];
  assign above_s = {sync2_q[3], sync2_q[1]};
  assign below_s = {sync2_q[4], sync2_q[2]};

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      undervoltage_lockout_prev_q <= 1'b1;
    else
      undervoltage_lockout_prev_q <= undervoltage_lockout_s;
  end

  // load fires once, on the cycle the lockout lets go
  assign load = undervoltage_lockout_prev_q & ~undervoltage_lockout_s;
  // writes during lockout or the load cycle are dropped
  assign wr_ok = reg_wr & ~undervoltage_lockout_s & ~load;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      serial_if_reset_q <= 1'b1;
    else
      serial_if_reset_q <= undervoltage_lockout_s | bus_stop;
  end

  // control register: dimming frequency, clock enable, divider
  always_ff @(posedge clk_sys)
  begin
    if (rst || undervoltage_lockout_s)
    begin
      dim_sel_q <= `PMUCR_DIM_RST;
      clk_en_q <= `PMUCR_CLKEN_RST;
      div_sel_q <= `PMUCR_DIV_RST;
    end
    else if (load)
    begin
      dim_sel_q <= otp_ctl[`PMUCR_DIM_MSB:`PMUCR_DIM_LSB];
      clk_en_q <= otp_ctl[`PMUCR_CLKEN_BIT];
      div_sel_q <= otp_ctl[`PMUCR_DIV_MSB:`PMUCR_DIV_LSB];
    end
    else if (wr_ok && decode(reg_addr) == pmucr_pkg::PMUCR_SEL_CTL)
    begin
      dim_sel_q <= reg_wdata[`PMUCR_DIM_MSB:`PMUCR_DIM_LSB];
      clk_en_q <= reg_wdata[`PMUCR_CLKEN_BIT];
      div_sel_q <= reg_wdata[`PMUCR_DIV_MSB:`PMUCR_DIV_LSB];
    end
  end

  // led current: only the otp load and the reset or lockout default change it
  always_ff @(posedge clk_sys)
  begin
    if (rst || undervoltage_lockout_s)
      led_level_q <= `PMUCR_LED_RST;
    else if (load)
      led_level_q <= otp_led;
  end

  // regulator enables, bit 0 regulator one, bit 1 regulator two
  // next value also clears power good, so no read sees a stale flag
  always_comb
  begin
    reg_en_d = reg_en_q;
    if (rst || undervoltage_lockout_s)
      reg_en_d = `PMUCR_EN_RST;
    else if (load)
      reg_en_d = otp_reg_en;
    else if (wr_ok && decode(reg_addr) == pmucr_pkg::PMUCR_SEL_REG)
      reg_en_d = {reg_wdata[`PMUCR_EN2_BIT],
                  reg_wdata[`PMUCR_EN1_BIT]};
  end

  always_ff @(posedge clk_sys)
  begin
    reg_en_q <= reg_en_d;
  end

  // power good with hysteresis; mid-band keeps the old flag
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pgood
      always_ff @(posedge clk_sys)
      begin
        if (rst || !reg_en_d[gi])
          pgood_q[gi] <= 1'b0;
        else if (above_s[gi])
          pgood_q[gi] <= 1'b1;
        else if (below_s[gi])
          pgood_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // read mux; spare bits and unmapped addresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    case (decode(reg_addr))
      pmucr_pkg::PMUCR_SEL_CTL:
      begin
        rdata_d[`PMUCR_DIM_MSB:`PMUCR_DIM_LSB] = dim_sel_q;
        rdata_d[`PMUCR_CLKEN_BIT] = clk_en_q;
        rdata_d[`PMUCR_DIV_MSB:`PMUCR_DIV_LSB] = div_sel_q;
      end
      pmucr_pkg::PMUCR_SEL_LED:
        rdata_d[`PMUCR_LED_MSB:`PMUCR_LED_LSB] = led_level_q;
      pmucr_pkg::PMUCR_SEL_REG:
      begin
        rdata_d[`PMUCR_PG2_BIT] = pgood_q[1];
        rdata_d[`PMUCR_PG1_BIT] = pgood_q[0];
        rdata_d[`PMUCR_EN2_BIT] = reg_en_q[1];
        rdata_d[`PMUCR_EN1_BIT] = reg_en_q[0];
      end
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
        reg_rdata_q <= rdata_d;
    end
  end

  assign gen.clk_en = clk_en_q;
  assign gen.reg_one_on = reg_en_q[0];
  assign gen.div_sel = div_sel_q;
  assign gen.dim_sel = dim_sel_q;

  pmucr_clock_output_pin u_clock_output_pin (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_pin(osc_pin),
    .gen(gen.clkgen)
  );

  pmucr_dimgen #(
    .BASE_CYCLES(DIM_BASE_CYCLES),
    .CNT_W(`PMUCR_DIM_CNT_W)
  ) u_dimgen (
    .clk_sys(clk_sys),
    .rst(rst),
    .gen(gen.dimgen)
  );

  // oscillator runs on the enable alone, not on regulator one
  assign osc_force_on_q = clk_en_q;
  assign clock_output_pin_q = gen.clk_pin;
  assign dim_pwm_q = gen.dim_pwm;
  assign reg_one_enable_q = reg_en_q[0];
  assign reg_two_enable_q = reg_en_q[1];
  assign reg_one_power_good_q = pgood_q[0];
  assign reg_two_power_good_q = pgood_q[1];

  default clocking cb @(posedge clk_sys); endclocking

  // reset checks look one edge on; $past has no history at time zero
  dim_reset_a: assert property (
    @(posedge clk_sys) rst |=> dim_sel_q == 2'h3)
    else $error("dimming field not 11 after reset");
  div_reset_a: assert property (
    @(posedge clk_sys) rst |=> div_sel_q == 2'h0 && !clk_en_q)
    else $error("divider or enable wrong after reset");
  osc_force_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_ok && reg_addr == 8'h03 && reg_wdata[2] |=> osc_force_on_q)
    else $error("oscillator not forced on by enable write");
  en_reset_a: assert property (
    @(posedge clk_sys) rst |=> reg_en_q == 2'h0)
    else $error("regulator enables not zero after reset");
  pg_rise_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_en_q[0] && above_s[0] ##1 reg_en_q[0] |-> pgood_q[0])
    else $error("power good one did not set");
  pg_fall_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    !above_s[1] && below_s[1] |=> !pgood_q[1])
    else $error("power good two did not clear");
  pg_off_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    !reg_en_q[0] |-> !pgood_q[0] && !reg_one_power_good_q)
    else $error("power good set on disabled regulator");
  led_read_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == 8'h04 |=>
    reg_rvalid_q && reg_rdata_q == {3'h0, led_level_q})
    else $error("led current read back wrong");
  otp_load_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(undervoltage_lockout_s) |=> dim_sel_q == $past(otp_ctl[4:3])
      && reg_en_q == $past(otp_reg_en) && led_level_q == $past(otp_led))
    else $error("otp defaults not loaded at lockout release");
  if_reset_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    bus_stop || undervoltage_lockout_s |=> serial_if_reset_q)
    else $error("serial interface reset missing");
  spare_zero_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == 8'h05 |=> reg_rdata_q[7:6] == 2'h0
      && reg_rdata_q[3:2] == 2'h0)
    else $error("spare bits read nonzero");
  led_fixed_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    !load && !undervoltage_lockout_s |=> $stable(led_level_q))
    else $error("led current changed without otp load");
  pg_two_off_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    !reg_en_q[1] |-> !pgood_q[1] && !reg_two_power_good_q)
    else $error("power good set on disabled regulator two");
  ctl_spare_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == 8'h03 |=> reg_rdata_q[7:5] == 3'h0)
    else $error("control spare bits read nonzero");
  lock_hold_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    undervoltage_lockout_s |=> reg_en_q == 2'h0 && !clk_en_q && dim_sel_q == 2'h3)
    else $error("registers not held at defaults in lockout");

  pg_rise_c: cover property (@(posedge clk_sys) $rose(pgood_q[0]));
  stop_c: cover property (@(posedge clk_sys) bus_stop);
  load_c: cover property (@(posedge clk_sys) load);
endmodule

// [tb/testbench.sv]
// self-checking bench for the clock, dimming and regulator register bank
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic undervoltage_lockout_pin = 1'b1;
  logic bus_stop = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic osc_pin = 1'b0;
  logic [1:0] above = 2'h0;
  logic [1:0] below = 2'h0;
  logic [7:0] otp_ctl = 8'h18;
  logic [4:0] otp_led = 5'h08;
  logic [1:0] otp_reg_en = 2'h0;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic clock_output_pin_q;
  logic dim_pwm_q;
  logic osc_force_on_q;
  logic reg_one_enable_q;
  logic reg_two_enable_q;
  logic reg_one_power_good_q;
  logic reg_two_power_good_q;
  logic serial_if_reset_q;
  logic [7:0] rd_v;
  int n_fail = 0;
  int compares = 0;
  int n;
  // rows: address, write data, expected read back
  localparam logic [23:0] ROWS [8] = '{24'h03FF1F, 24'h030000,
    24'h031B1B, 24'h04FF08, 24'h05FF03, 24'h050000, 24'h09FF00,
    24'h031818};

  always #2 clk_sys = ~clk_sys;
  // free-running crystal, unrelated in phase to clk_sys
  always #20.83 osc_pin = ~osc_pin;

  pmucr_top #(.DIM_BASE_CYCLES(40)) uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .undervoltage_lockout_pin(undervoltage_lockout_pin),
    .bus_stop(bus_stop),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q),
    .otp_ctl(otp_ctl),
    .otp_led(otp_led),
    .otp_reg_en(otp_reg_en),
    .osc_pin(osc_pin),
    .reg_one_above_pin(above[0]),
    .reg_one_below_pin(below[0]),
    .reg_two_above_pin(above[1]),
    .reg_two_below_pin(below[1]),
    .clock_output_pin_q(clock_output_pin_q),
    .dim_pwm_q(dim_pwm_q),
    .osc_force_on_q(osc_force_on_q),
    .reg_one_enable_q(reg_one_enable_q),
    .reg_two_enable_q(reg_two_enable_q),
    .reg_one_power_good_q(reg_one_power_good_q),
    .reg_two_power_good_q(reg_two_power_good_q),
    .serial_if_reset_q(serial_if_reset_q)
  );

  task automatic close_out();
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask

  // counts are coarse: osc and clk_sys drift, so allow a small slack
  task automatic chk_rng(input string nm, input int e, input int g,
                         input int tol);
    compares++;
    if (g < e - tol || g > e + tol)
    begin
      n_fail++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bit got;
    got = 0;
    d = 8'h00;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    for (int i = 0; i < 4 && !got; i++)
    begin
      #1;
      if (reg_rvalid_q === 1'b1)
      begin
        d = reg_rdata_q;
        got = 1;
      end
      else
        @(posedge clk_sys);
    end
    if (!got)
    begin
      n_fail++;
      close_out();
    end
  endtask

  // which 0: rising edges of clock output, 1: toggles of dimming pwm
  task automatic count_ev(input int which, input int cyc, output int c);
    logic p;
    logic s;
    c = 0;
    #1;
    p = which == 0 ? clock_output_pin_q : dim_pwm_q;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      #1;
      s = which == 0 ? clock_output_pin_q : dim_pwm_q;
      if (which == 0 ? (s && !p) : (s != p))
        c++;
      p = s;
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  initial
  begin
    wait_cyc(20);
    rst <= 1'b0;
    undervoltage_lockout_pin <= 1'b0;
    wait_cyc(6);
    rd(8'h03, rd_v);
    chk8("ctl_dflt", 8'h18, rd_v);
    rd(8'h04, rd_v);
    chk8("led_dflt", 8'h08, rd_v);
    rd(8'h05, rd_v);
    chk8("reg_dflt", 8'h00, rd_v);
    foreach (ROWS[i])
    begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], rd_v);
      chk8("row_rd", ROWS[i][7:0], rd_v);
    end
    // oscillator forced on but regulator one off: output stays low
    wr(8'h05, 8'h00);
    wr(8'h03, 8'h04);
    wait_cyc(4);
    chk1("osc_force", 1'b1, osc_force_on_q);
    count_ev(0, 200, n);
    chk_rng("clk_no_ldo", 0, n, 0);
    wr(8'h05, 8'h01);
    wait_cyc(2);
    chk1("en1", 1'b1, reg_one_enable_q);
    for (int d = 0; d < 4; d++)
    begin
      wr(8'h03, 8'h04 | 8'(d));
      wait_cyc(20);
      count_ev(0, 1000, n);
      chk_rng("clk_rate", 96 >> d, n, 2);
    end
    wr(8'h03, 8'h00);
    wait_cyc(4);
    chk1("osc_off", 1'b0, osc_force_on_q);
    count_ev(0, 200, n);
    chk_rng("clk_off", 0, n, 0);
    chk1("clk_low", 1'b0, clock_output_pin_q);
    // half period is (40/2) << select cycles
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h03, 8'(s) << 3);
      wait_cyc(200);
      count_ev(1, 1280, n);
      chk_rng("dim_rate", 64 >> s, n, 1);
    end
    // power good hysteresis per regulator
    for (int r = 0; r < 2; r++)
    begin
      wr(8'h05, 8'(1 << r));
      above[r] <= 1'b1;
      wait_cyc(6);
      rd(8'h05, rd_v);
      chk8("pg_set", 8'(8'h11 << r), rd_v);
      above[r] <= 1'b0;
      wait_cyc(6);
      rd(8'h05, rd_v);
      chk8("pg_hold", 8'(8'h11 << r), rd_v);
      below[r] <= 1'b1;
      wait_cyc(6);
      rd(8'h05, rd_v);
      chk8("pg_clr", 8'(8'h01 << r), rd_v);
      below[r] <= 1'b0;
      above[r] <= 1'b1;
      wait_cyc(6);
      wr(8'h05, 8'h00);
      wait_cyc(2);
      rd(8'h05, rd_v);
      chk8("pg_dis", 8'h00, rd_v);
      chk1("pg1_pin", 1'b0, reg_one_power_good_q);
      chk1("pg2_pin", 1'b0, reg_two_power_good_q);
      above[r] <= 1'b0;
    end
    @(posedge clk_sys);
    bus_stop <= 1'b1;
    @(posedge clk_sys);
    bus_stop <= 1'b0;
    #1;
    chk1("stop_rst", 1'b1, serial_if_reset_q);
    wait_cyc(2);
    chk1("stop_end", 1'b0, serial_if_reset_q);
    // lockout: writes dropped, defaults reloaded at release
    wr(8'h03, 8'h07);
    wr(8'h05, 8'h03);
    undervoltage_lockout_pin <= 1'b1;
    wait_cyc(4);
    chk1("undervoltage_lockout_rst", 1'b1, serial_if_reset_q);
    // new otp image, so the reload differs from the reset values
    otp_ctl <= 8'h0D;
    otp_led <= 5'h11;
    otp_reg_en <= 2'h2;
    wr(8'h03, 8'h04);
    wait_cyc(2);
    chk1("undervoltage_lockout_osc", 1'b0, osc_force_on_q);
    chk1("undervoltage_lockout_en2", 1'b0, reg_two_enable_q);
    undervoltage_lockout_pin <= 1'b0;
    wait_cyc(6);
    rd(8'h03, rd_v);
    chk8("reload_ctl", 8'h0D, rd_v);
    rd(8'h05, rd_v);
    chk8("reload_reg", 8'h02, rd_v);
    rd(8'h04, rd_v);
    chk8("reload_led", 8'h11, rd_v);
    close_out();
  end
endmodule
